// *** rtl/charge_cycle_controller.sv ***
// Sequencer of a single-cell linear charger: stages, timers, flags and targets.
`timescale 1ns/1ps
`default_nettype none
`include "charge_defs.svh"

module charge_cycle_controller #(
	parameter logic [63:0] PRECHARGE_CYC = `CYC_PRECHARGE,
	parameter logic [63:0] CC_INT_CYC = `CYC_CC_INT,
	parameter logic [63:0] CV_CYC = `CYC_CV,
	parameter logic [63:0] TOPOFF_CYC = `CYC_TOPOFF,
	parameter logic [63:0] STATUS_DELAY_CYC = `CYC_STATUS_DELAY,
	parameter logic [63:0] STEP_CYC = 64'h0000_0000_0000_0100
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Comparator pins from the analog front end (asynchronous)
	input wire logic supply_valid_pin,
	input wire logic program_short_pin,
	input wire logic bat_above_precharge_pin,
	input wire logic bat_at_full_voltage_pin,
	input wire logic bat_recharge_drop_pin,
	input wire logic current_below_term_pin,
	input wire logic therm_below_10_pin,
	input wire logic therm_below_30_pin,
	input wire logic therm_above_75_pin,
	input wire logic therm_above_95_pin,
	// Tri-level mode pin, decoded as driven high and driven low
	input wire logic mode_high_pin,
	input wire logic mode_low_pin,
	// Timeout set pin, decoded as tied to ground or to the reference rail
	input wire logic timeout_ground_pin,
	input wire logic timeout_rail_pin,
	input wire logic ext_cc_expired_pin,
	// Regulation commands
	output charge_pkg::input_mode_type input_mode,
	output logic output_enable,
	output logic voltage_regulation,
	output logic [6:0] current_target_pct,
	output logic [6:0] term_current_pct,
	output logic no_battery_mode,
	output charge_pkg::charge_state_type charge_state,
	// Open-drain status flags
	output logic supply_ok_flag_out,
	output logic supply_ok_flag_oe,
	output logic charging_flag_out,
	output logic charging_flag_oe
);
	import charge_pkg::*;

	// -------------------------------------------------------------------------
	// Input synchronisers
	// -------------------------------------------------------------------------
	localparam int NSYNC = 15;
	logic [NSYNC-1:0] pins_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	assign pins_raw = {supply_valid_pin, program_short_pin, bat_above_precharge_pin,
		bat_at_full_voltage_pin, bat_recharge_drop_pin, current_below_term_pin,
		therm_below_10_pin, therm_below_30_pin, therm_above_75_pin, therm_above_95_pin,
		mode_high_pin, mode_low_pin, timeout_ground_pin, timeout_rail_pin, ext_cc_expired_pin};

	// Two flops per pin; only the second stage is read by logic.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else if (clk_en) begin
					sync1_q[gi] <= pins_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	wire supply_valid = sync2_q[14];
	wire program_short = sync2_q[13];
	wire bat_above_pre = sync2_q[12];
	wire bat_full = sync2_q[11];
	wire bat_dropped = sync2_q[10];
	wire below_term = sync2_q[9];
	wire therm_lt10 = sync2_q[8];
	wire therm_lt30 = sync2_q[7];
	wire therm_gt75 = sync2_q[6];
	wire therm_gt95 = sync2_q[5];
	wire mode_hi = sync2_q[4];
	wire mode_lo = sync2_q[3];
	wire tmo_gnd = sync2_q[2];
	wire tmo_rail = sync2_q[1];
	wire ext_cc_exp = sync2_q[0];

	// -------------------------------------------------------------------------
	// Decoded configuration and conditions
	// -------------------------------------------------------------------------
	// Driven low wins over high if the comparators ever both trip.
	wire input_mode_type mode_dec = mode_lo ? MODE_ADAPTER : (mode_hi ? MODE_USB_HIGH : MODE_USB_LOW);
	wire timer_cfg_type timer_cfg = tmo_gnd ? TIMER_OFF : (tmo_rail ? TIMER_INTERNAL : TIMER_EXTERNAL);
	wire timer_on = (timer_cfg != TIMER_OFF);
	// A program pin short acts as a logical reset of the whole sequencer.
	wire hold_reset = program_short;
	wire therm_disable = therm_lt10;
	wire therm_suspend = therm_lt30 || therm_gt75;
	wire no_battery = therm_gt95 && !therm_disable;
	wire usb_low = (mode_dec == MODE_USB_LOW);

	// -------------------------------------------------------------------------
	// State and counters
	// -------------------------------------------------------------------------
	charge_state_type state_q;
	charge_state_type state_d;
	logic [63:0] stage_cnt_q;
	logic [63:0] step_cnt_q;
	logic [63:0] delay_cnt_q;
	logic flag_hold_q;
	logic flag_hold_d;
	logic recharge_q;
	logic recharge_d;
	logic fault_q;
	logic delay_run_q;
	logic term_ok;
	wire stage_change = (state_d != state_q);

	// Termination qualifier with its recent-load window.
	load_peak_window u_window (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.clear(state_q != ST_CV && state_q != ST_TOPOFF),
		.below_term(below_term),
		.term_ok(term_ok)
	);

	// Stage limits; a timer that is off never expires.
	wire pre_expired = timer_on && (stage_cnt_q >= PRECHARGE_CYC - 64'd1);
	wire cc_expired = (timer_cfg == TIMER_INTERNAL) ? (stage_cnt_q >= CC_INT_CYC - 64'd1) :
		(timer_cfg == TIMER_EXTERNAL) && ext_cc_exp;
	wire cv_expired = timer_on && (stage_cnt_q >= CV_CYC - 64'd1);
	wire topoff_done = stage_cnt_q >= TOPOFF_CYC - 64'd1;
	wire step_done = step_cnt_q >= STEP_CYC - 64'd1;
	wire terminate = term_ok || cv_expired;
	wire in_cc = (state_q == ST_CC1) || (state_q == ST_CC2) || (state_q == ST_CC3);

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		flag_hold_d = flag_hold_q;
		recharge_d = recharge_q;
		case (state_q)
			ST_IDLE: begin
				if (supply_valid && !therm_disable) begin
					state_d = ST_PRECHARGE;
					flag_hold_d = 1'b1;
					recharge_d = 1'b0;
				end
			end
			ST_PRECHARGE: begin
				if (pre_expired) begin
					state_d = ST_FAULT;
				end else if (bat_above_pre) begin
					state_d = ST_CC1;
				end
			end
			ST_CC1, ST_CC2, ST_CC3: begin
				if (cc_expired) begin
					state_d = ST_FAULT;
				end else if (bat_full) begin
					state_d = ST_CV;
				end else if (state_q == ST_CC1 && step_done && !usb_low) begin
					state_d = ST_CC2;
				end else if (state_q == ST_CC2 && step_done && !usb_low) begin
					state_d = ST_CC3;
				end else if (state_q == ST_CC2 && usb_low) begin
					state_d = ST_CC1;
				end
			end
			ST_CV: begin
				if (terminate) begin
					state_d = timer_on ? ST_TOPOFF : ST_MONITOR;
				end
			end
			ST_TOPOFF: begin
				if (topoff_done) begin
					state_d = ST_MONITOR;
				end
			end
			ST_MONITOR: begin
				if (bat_dropped) begin
					state_d = ST_PRECHARGE;
					recharge_d = 1'b1;
				end
			end
			ST_FAULT: begin
				state_d = ST_FAULT;
			end
			ST_NO_BATTERY: begin
				if (!therm_gt95) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Loss of supply or battery overrides every stage.
		if (!supply_valid) begin
			state_d = ST_IDLE;
			flag_hold_d = 1'b0;
		end else if (no_battery) begin
			state_d = ST_NO_BATTERY;
		end
	end

	// -------------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			flag_hold_q <= 1'b0;
			recharge_q <= 1'b0;
		end else if (clk_en) begin
			if (hold_reset) begin
				state_q <= ST_IDLE;
				flag_hold_q <= 1'b0;
				recharge_q <= 1'b0;
			end else begin
				state_q <= state_d;
				flag_hold_q <= flag_hold_d && !(delay_run_q && delay_cnt_q >= STATUS_DELAY_CYC - 64'd1);
				recharge_q <= recharge_d;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Stage timer and soft-start step counter
	// -------------------------------------------------------------------------
	// The stage timer stops while the thermistor suspends charging, so a cold or
	// hot battery does not burn its safety budget.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_cnt_q <= 64'h0;
			step_cnt_q <= 64'h0;
		end else if (clk_en) begin
			if (hold_reset || stage_change) begin
				stage_cnt_q <= 64'h0;
				step_cnt_q <= 64'h0;
			end else begin
				if (!therm_suspend && state_q != ST_MONITOR && state_q != ST_FAULT) begin
					stage_cnt_q <= stage_cnt_q + 64'h1;
				end
				if (in_cc && !step_done) begin
					step_cnt_q <= step_cnt_q + 64'h1;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Status delay and fault latch
	// -------------------------------------------------------------------------
	// The delay starts at termination and runs on into the monitor state.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			delay_cnt_q <= 64'h0;
			delay_run_q <= 1'b0;
			fault_q <= 1'b0;
		end else if (clk_en) begin
			if (hold_reset || !supply_valid || state_d == ST_PRECHARGE) begin
				delay_cnt_q <= 64'h0;
				delay_run_q <= 1'b0;
			end else if (state_q == ST_CV && state_d != ST_CV) begin
				delay_cnt_q <= 64'h0;
				delay_run_q <= 1'b1;
			end else if (delay_run_q && delay_cnt_q < STATUS_DELAY_CYC - 64'd1) begin
				delay_cnt_q <= delay_cnt_q + 64'h1;
			end
			fault_q <= !hold_reset && supply_valid && (state_d == ST_FAULT);
		end
	end

	// -------------------------------------------------------------------------
	// Current targets and regulation commands
	// -------------------------------------------------------------------------
	wire charging = !therm_suspend && !therm_disable && !hold_reset &&
		(state_q == ST_PRECHARGE || in_cc || state_q == ST_CV || state_q == ST_TOPOFF);
	wire [6:0] pct_d = !charging ? `PCT_NONE :
		(state_q == ST_PRECHARGE) ? `PCT_STEP1 :
		(state_q == ST_CC1 || usb_low) ? `PCT_STEP1 :
		(state_q == ST_CC2) ? `PCT_STEP2 : `PCT_FULL;

	// Outputs come from flops so the analog side sees clean levels.
	logic [6:0] pct_q;
	logic out_en_q;
	logic cv_q;
	logic nobat_q;
	logic sup_low_q;
	logic chg_low_q;
	input_mode_type mode_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pct_q <= `PCT_NONE;
			out_en_q <= 1'b0;
			cv_q <= 1'b0;
			nobat_q <= 1'b0;
			sup_low_q <= 1'b0;
			chg_low_q <= 1'b0;
			mode_q <= MODE_ADAPTER;
		end else if (clk_en) begin
			pct_q <= pct_d;
			out_en_q <= charging;
			cv_q <= charging && (state_q == ST_CV || state_q == ST_TOPOFF);
			nobat_q <= (state_q == ST_NO_BATTERY);
			sup_low_q <= supply_valid && !hold_reset && !fault_q;
			chg_low_q <= flag_hold_q && !recharge_q && !hold_reset;
			mode_q <= mode_dec;
		end
	end

	assign current_target_pct = pct_q;
	assign term_current_pct = `PCT_TERM;
	assign output_enable = out_en_q;
	assign voltage_regulation = cv_q;
	assign no_battery_mode = nobat_q;
	assign input_mode = mode_q;
	assign charge_state = state_q;
	// Open-drain: output is always low, enable pulls the pin.
	assign supply_ok_flag_out = 1'b0;
	assign supply_ok_flag_oe = sup_low_q;
	assign charging_flag_out = 1'b0;
	assign charging_flag_oe = chg_low_q;

endmodule : charge_cycle_controller
`default_nettype wire

// *** rtl/charge_defs.svh ***
// Timing counts and fixed fractions of the charge cycle controller.
`ifndef CHARGE_DEFS_SVH
`define CHARGE_DEFS_SVH

// -----------------------------------------------------------------------------
// Clock and time units
// -----------------------------------------------------------------------------
`define CLK_HZ 40000000
`define TIME_PRECHARGE_MIN 45
`define TIME_CC_INT_HOURS 3
`define TIME_CV_HOURS 3
`define TIME_TOPOFF_MIN 45
`define TIME_STATUS_DELAY_S 20
`define TIME_LOAD_WINDOW_US 300

// -----------------------------------------------------------------------------
// Derived cycle counts (64-bit, the long ones exceed 2^32)
// -----------------------------------------------------------------------------
`define CYC_PRECHARGE (64'd60 * `TIME_PRECHARGE_MIN * `CLK_HZ)
`define CYC_CC_INT (64'd3600 * `TIME_CC_INT_HOURS * `CLK_HZ)
`define CYC_CV (64'd3600 * `TIME_CV_HOURS * `CLK_HZ)
`define CYC_TOPOFF (64'd60 * `TIME_TOPOFF_MIN * `CLK_HZ)
`define CYC_STATUS_DELAY (64'd1 * `TIME_STATUS_DELAY_S * `CLK_HZ)
`define CYC_LOAD_WINDOW ((64'd1 * `TIME_LOAD_WINDOW_US * `CLK_HZ + 64'd999999) / 64'd1000000)

// -----------------------------------------------------------------------------
// Current targets in percent of the programmed fast-charge current
// -----------------------------------------------------------------------------
`define PCT_STEP1 7'd20
`define PCT_STEP2 7'd60
`define PCT_FULL 7'd100
`define PCT_TERM 7'd10
`define PCT_NONE 7'd0

`endif

// *** rtl/charge_pkg.sv ***
// Types of the charge cycle controller.
package charge_pkg;

	// Input mode decoded from the tri-level mode pin.
	typedef enum logic [1:0] {
		MODE_ADAPTER = 2'b00,
		MODE_USB_LOW = 2'b01,
		MODE_USB_HIGH = 2'b10
	} input_mode_type;

	// Timer configuration decoded from the timeout set pin.
	typedef enum logic [1:0] {
		TIMER_OFF = 2'b00,
		TIMER_INTERNAL = 2'b01,
		TIMER_EXTERNAL = 2'b10
	} timer_cfg_type;

	// Charge sequence states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_PRECHARGE = 4'b0001,
		ST_CC1 = 4'b0010,
		ST_CC2 = 4'b0011,
		ST_CC3 = 4'b0100,
		ST_CV = 4'b0101,
		ST_TOPOFF = 4'b0110,
		ST_MONITOR = 4'b0111,
		ST_FAULT = 4'b1000,
		ST_NO_BATTERY = 4'b1001
	} charge_state_type;

endpackage : charge_pkg

// *** rtl/load_peak_window.sv ***
// Termination qualifier that needs a low-current window before reporting.
`timescale 1ns/1ps
`default_nettype none
`include "charge_defs.svh"

module load_peak_window (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic below_term,
	// Result
	output logic term_ok
);

	localparam logic [15:0] WINDOW_CYC = 16'(`CYC_LOAD_WINDOW);

	logic [15:0] count_q;
	logic [15:0] count_d;
	logic term_q;

	// -------------------------------------------------------------------------
	// Window counter
	// -------------------------------------------------------------------------
	// Any sample at or above the threshold restarts the window, so the peak of the
	// recent load must itself be below it.
	assign count_d = (clear || !below_term) ? 16'h0000 :
		(count_q == WINDOW_CYC) ? count_q : count_q + 16'h0001;

	// Register the count and the qualified result.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 16'h0000;
			term_q <= 1'b0;
		end else if (clk_en) begin
			count_q <= count_d;
			term_q <= (count_d == WINDOW_CYC);
		end
	end

	assign term_ok = term_q;

endmodule : load_peak_window
`default_nettype wire

// *** sim/charge_cycle_props.sv ***
// Concurrent checks on the ports of the charge cycle controller.
`timescale 1ns/1ps
`default_nettype none

module charge_cycle_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Comparator pins
	input wire logic supply_valid_pin,
	input wire logic program_short_pin,
	input wire logic therm_below_10_pin,
	input wire logic therm_below_30_pin,
	input wire logic therm_above_75_pin,
	input wire logic therm_above_95_pin,
	// Regulation commands and flags
	input wire charge_pkg::input_mode_type input_mode,
	input wire logic output_enable,
	input wire logic voltage_regulation,
	input wire logic [6:0] current_target_pct,
	input wire logic [6:0] term_current_pct,
	input wire logic no_battery_mode,
	input wire charge_pkg::charge_state_type charge_state,
	input wire logic supply_ok_flag_oe,
	input wire logic charging_flag_oe
);
	import charge_pkg::*;

	// ---------------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Pin conditions get six cycles to pass the synchronisers and the state register.
	property p_short;
		program_short_pin [*6] |-> !output_enable && !supply_ok_flag_oe && !charging_flag_oe;
	endproperty
	a_short: assert property (p_short) else $error("short pin does not hold the logic off");
	property p_term;
		$past(reset_n) |-> term_current_pct == 7'h0a;
	endproperty
	a_term: assert property (p_term) else $error("termination level is not ten percent");
	property p_levels;
		current_target_pct inside {7'h00, 7'h14, 7'h3c, 7'h64};
	endproperty
	a_levels: assert property (p_levels) else $error("current target off the step table");
	property p_cold;
		therm_below_10_pin [*6] |-> !output_enable;
	endproperty
	a_cold: assert property (p_cold) else $error("output on with thermistor below ten percent");
	property p_suspend;
		((therm_below_30_pin || therm_above_75_pin) && !therm_above_95_pin) [*6] |-> !output_enable;
	endproperty
	a_suspend: assert property (p_suspend) else $error("output on outside thermistor window");
	property p_nobat;
		(therm_above_95_pin && supply_valid_pin && !program_short_pin) [*6] |-> no_battery_mode;
	endproperty
	a_nobat: assert property (p_nobat) else $error("no-battery mode missing");
	property p_cv;
		charge_state == ST_CV [*2] |-> voltage_regulation;
	endproperty
	a_cv: assert property (p_cv) else $error("voltage regulation off in CV");
	property p_fault;
		charge_state == ST_FAULT [*2] |-> !supply_ok_flag_oe && !output_enable;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not shown on supply flag");
	property p_pre;
		charge_state == ST_PRECHARGE [*2] ##0 output_enable |-> current_target_pct == 7'h14;
	endproperty
	a_pre: assert property (p_pre) else $error("pre-charge target not one fifth");
	property p_cc1;
		charge_state == ST_CC1 [*2] ##0 output_enable |-> current_target_pct == 7'h14;
	endproperty
	a_cc1: assert property (p_cc1) else $error("first soft-start step not twenty percent");
	property p_cc3;
		(charge_state == ST_CC3 && input_mode != MODE_USB_LOW) [*2] ##0 output_enable |-> current_target_pct == 7'h64;
	endproperty
	a_cc3: assert property (p_cc3) else $error("last soft-start step not full current");
	property p_mon;
		charge_state == ST_MONITOR [*2] |-> !output_enable;
	endproperty
	a_mon: assert property (p_mon) else $error("output on in monitor state");

	// Main scenarios reached.
	c_topoff: cover property (charge_state == ST_TOPOFF);
	c_fault: cover property (charge_state == ST_FAULT);
	c_nobat: cover property (charge_state == ST_NO_BATTERY);
endmodule : charge_cycle_props

bind charge_cycle_controller charge_cycle_props chk_u (.clk, .reset_n, .supply_valid_pin, .program_short_pin,
	.therm_below_10_pin, .therm_below_30_pin, .therm_above_75_pin, .therm_above_95_pin, .input_mode, .output_enable,
	.voltage_regulation, .current_target_pct, .term_current_pct, .no_battery_mode, .charge_state,
	.supply_ok_flag_oe, .charging_flag_oe);

`default_nettype wire

// *** sim/host_gpio_model.sv ***
// Host processor GPIO model: drives the tri-level mode pin and reads the flag lines.
`timescale 1ns/1ps
`default_nettype none

module host_gpio_model (
	// Mode request
	input wire charge_pkg::input_mode_type mode_req,
	output logic mode_high_pin,
	output logic mode_low_pin,
	// Open-drain flags
	input wire logic ok_out,
	input wire logic ok_oe,
	input wire logic chg_out,
	input wire logic chg_oe,
	output logic ok_level,
	output logic chg_level
);
	import charge_pkg::*;

	// High drives the pin up, adapter grounds it, USB low leaves it floating.
	assign mode_high_pin = (mode_req == MODE_USB_HIGH);
	assign mode_low_pin = (mode_req == MODE_ADAPTER);
	// Host pull-ups lift a released line, so only the enable decides the level.
	assign ok_level = ok_oe ? ok_out : 1'h1;
	assign chg_level = chg_oe ? chg_out : 1'h1;
endmodule : host_gpio_model

`default_nettype wire

// *** sim/test_charge_cycle_controller.sv ***
// Self-checking testbench of the charge cycle controller.
`timescale 1ns/1ps
`default_nettype none

module test_charge_cycle_controller;
	import charge_pkg::*;

	// ---------------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------------
	logic clk = 1'h0;
	logic reset_n, supply_valid_pin, program_short_pin, bat_above_precharge_pin, bat_at_full_voltage_pin;
	logic bat_recharge_drop_pin, current_below_term_pin, therm_below_10_pin, therm_below_30_pin;
	logic therm_above_75_pin, therm_above_95_pin, timeout_ground_pin, timeout_rail_pin, ext_cc_expired_pin;
	logic mode_high_pin, mode_low_pin, output_enable, voltage_regulation, no_battery_mode;
	logic supply_ok_flag_out, supply_ok_flag_oe, charging_flag_out, charging_flag_oe, ok_level, chg_level;
	logic [6:0] current_target_pct, term_current_pct;
	input_mode_type input_mode, mode_req;
	charge_state_type charge_state, exp_q[$];
	charge_state_type last_state = ST_IDLE;
	logic [31:0] rnd = 32'h0000_0010;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic clk_en = 1'h1;

	// Short stage times keep the run brief; CV keeps its long limit so current ends it.
	charge_cycle_controller #(.PRECHARGE_CYC(64'h0c8), .CC_INT_CYC(64'h12c),
		.TOPOFF_CYC(64'h0c8), .STATUS_DELAY_CYC(64'h064), .STEP_CYC(64'h010)) dut_u (.clk, .reset_n,
		.clk_en, .supply_valid_pin, .program_short_pin, .bat_above_precharge_pin, .bat_at_full_voltage_pin,
		.bat_recharge_drop_pin, .current_below_term_pin, .therm_below_10_pin, .therm_below_30_pin,
		.therm_above_75_pin, .therm_above_95_pin, .mode_high_pin, .mode_low_pin, .timeout_ground_pin,
		.timeout_rail_pin, .ext_cc_expired_pin, .input_mode, .output_enable, .voltage_regulation,
		.current_target_pct, .term_current_pct, .no_battery_mode, .charge_state, .supply_ok_flag_out,
		.supply_ok_flag_oe, .charging_flag_out, .charging_flag_oe);
	host_gpio_model host_u (.mode_req, .mode_high_pin, .mode_low_pin, .ok_out(supply_ok_flag_out),
		.ok_oe(supply_ok_flag_oe), .chg_out(charging_flag_out), .chg_oe(charging_flag_oe), .ok_level, .chg_level);

	// ---------------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic report_err(input string m);
		err_total++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : report_err
	task automatic chk_state(input charge_state_type e);
		cmp_count++;
		if (charge_state !== e) report_err($sformatf("state %0d, expected %0d", charge_state, e));
	endtask : chk_state
	task automatic chk_bit(input logic got, input logic e, input string m);
		cmp_count++;
		if (got !== e) report_err(m);
	endtask : chk_bit
	task automatic chk_pct(input logic [6:0] e);
		cmp_count++;
		if (current_target_pct !== e) report_err($sformatf("target %0d, expected %0d", current_target_pct, e));
	endtask : chk_pct
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// Waits a bounded time for every noted state to be seen.
	task automatic drain(input int limit);
		int i;
		i = 0;
		while (exp_q.size() != 0 && i < limit) begin
			@(negedge clk);
			i++;
		end
		if (exp_q.size() != 0) begin
			report_err("expected state not reached");
			exp_q.delete();
		end
	endtask : drain
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ---------------------------------------------------------------------
	// Clock, watchdog and state monitor
	// ---------------------------------------------------------------------
	always #12.5 clk = ~clk;
	// A hang is cut well beyond the roughly 25000 cycles the run needs.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			report_err("timeout");
			test_done();
		end
	end
	// Every state change takes the oldest note; a change nobody noted is an error.
	always @(negedge clk) begin
		if (charge_state !== last_state) begin
			last_state = charge_state;
			if (exp_q.size() == 0) report_err("unexpected state change");
			else chk_state(exp_q.pop_front());
		end
	end

	// ---------------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------------
	initial begin
		{reset_n, supply_valid_pin, program_short_pin, bat_above_precharge_pin, bat_at_full_voltage_pin,
			bat_recharge_drop_pin, current_below_term_pin, therm_below_10_pin, therm_below_30_pin,
			therm_above_75_pin, therm_above_95_pin, timeout_ground_pin, ext_cc_expired_pin} = 13'h0000;
		timeout_rail_pin = 1'h1;
		mode_req = MODE_ADAPTER;
		tick(5);
		reset_n = 1'h1;
		tick(2);
		// Internal timer, adapter mode: full cycle, top-off, monitor, then a timed recharge.
		exp_q = {ST_PRECHARGE};
		supply_valid_pin = 1'h1;
		drain(20);
		tick(3);
		chk_bit(ok_level, 1'h0, "supply flag not low");
		chk_bit(chg_level, 1'h0, "charging flag not low");
		chk_pct(7'h14);
		exp_q = {ST_CC1, ST_CC2, ST_CC3};
		bat_above_precharge_pin = 1'h1;
		drain(100);
		tick(3);
		chk_pct(7'h64);
		exp_q = {ST_CV};
		bat_at_full_voltage_pin = 1'h1;
		drain(20);
		// Random short low-current dips must not terminate.
		repeat (8) begin
			rnd = xs(rnd);
			current_below_term_pin = 1'h1;
			tick(int'(rnd[2:0]) + 1);
			current_below_term_pin = 1'h0;
			tick(2);
		end
		exp_q = {ST_TOPOFF};
		current_below_term_pin = 1'h1;
		drain(12100);
		tick(90);
		chk_bit(chg_level, 1'h0, "charging flag released early");
		tick(20);
		chk_bit(chg_level, 1'h1, "charging flag not released");
		exp_q = {ST_MONITOR};
		drain(150);
		{bat_above_precharge_pin, bat_at_full_voltage_pin, current_below_term_pin} = 3'h0;
		tick(30);
		clk_en = 1'h0;
		bat_recharge_drop_pin = 1'h1;
		rnd = xs(rnd);
		tick(int'(rnd[3:0]) + 4);
		chk_state(ST_MONITOR);
		clk_en = 1'h1;
		exp_q = {ST_PRECHARGE};
		bat_recharge_drop_pin = 1'h1;
		drain(20);
		bat_recharge_drop_pin = 1'h0;
		tick(3);
		chk_bit(chg_level, 1'h1, "recharge pulled charging flag");
		exp_q = {ST_FAULT};
		drain(250);
		tick(3);
		chk_bit(ok_level, 1'h1, "supply flag low in fault");
		exp_q = {ST_IDLE};
		supply_valid_pin = 1'h0;
		drain(20);
		// Timer off, USB low power: held at the first step, no timeouts, no top-off.
		timeout_rail_pin = 1'h0;
		timeout_ground_pin = 1'h1;
		mode_req = MODE_USB_LOW;
		exp_q = {ST_PRECHARGE};
		supply_valid_pin = 1'h1;
		drain(20);
		exp_q = {ST_CC1};
		bat_above_precharge_pin = 1'h1;
		drain(20);
		tick(350);
		chk_pct(7'h14);
		chk_bit(input_mode === MODE_USB_LOW, 1'h1, "mode not USB low");
		exp_q = {ST_CV, ST_MONITOR};
		bat_at_full_voltage_pin = 1'h1;
		tick(5);
		current_below_term_pin = 1'h1;
		drain(12100);
		exp_q = {ST_IDLE};
		supply_valid_pin = 1'h0;
		{bat_above_precharge_pin, bat_at_full_voltage_pin, current_below_term_pin} = 3'h0;
		drain(20);
		// External timer, USB high power: full ramp, external expiry is a fault that holds after the pin releases until supply loss clears it.
		timeout_ground_pin = 1'h0;
		mode_req = MODE_USB_HIGH;
		exp_q = {ST_PRECHARGE};
		supply_valid_pin = 1'h1;
		drain(20);
		exp_q = {ST_CC1, ST_CC2, ST_CC3};
		bat_above_precharge_pin = 1'h1;
		drain(100);
		tick(3);
		chk_pct(7'h64);
		exp_q = {ST_FAULT};
		ext_cc_expired_pin = 1'h1;
		drain(20);
		{ext_cc_expired_pin, bat_above_precharge_pin} = 2'h0;
		tick(20);
		chk_bit(ok_level, 1'h1, "supply flag low in fault");
		chk_bit(chg_level, 1'h0, "charging flag released in fault");
		exp_q = {ST_IDLE};
		supply_valid_pin = 1'h0;
		drain(20);
		// Thermistor windows, missing battery and a shorted program pin.
		exp_q = {ST_PRECHARGE};
		supply_valid_pin = 1'h1;
		drain(20);
		therm_below_30_pin = 1'h1;
		tick(10);
		chk_bit(output_enable, 1'h0, "output on while cold");
		therm_below_10_pin = 1'h1;
		tick(10);
		chk_bit(output_enable, 1'h0, "output on below ten percent");
		{therm_below_10_pin, therm_below_30_pin} = 2'h0;
		tick(10);
		chk_bit(output_enable, 1'h1, "output not resumed");
		exp_q = {ST_NO_BATTERY};
		{therm_above_75_pin, therm_above_95_pin} = 2'h3;
		drain(20);
		exp_q = {ST_IDLE, ST_PRECHARGE};
		{therm_above_75_pin, therm_above_95_pin} = 2'h0;
		drain(20);
		exp_q = {ST_IDLE};
		program_short_pin = 1'h1;
		drain(20);
		tick(5);
		chk_bit(ok_level, 1'h1, "supply flag low while shorted");
		chk_bit(output_enable, 1'h0, "output on while shorted");
		{supply_valid_pin, program_short_pin} = 2'h0;
		tick(20);
		test_done();
	end
endmodule : test_charge_cycle_controller

`default_nettype wire
